// ===== design/i2m_map.svh
`ifndef I2M_MAP_SVH
`define I2M_MAP_SVH
`define I2M_MEM_WORDS       65536
// Type code value is arbitrary
`define I2M_TYPE_CODE       4'h5
`define I2M_SCL_HS_KHZ      3400
`define I2M_SCL_FMP_KHZ     1000
`define I2M_CLK_MHZ         200
`define I2M_BIT_LAST        3'h7
`define I2M_BUF_DEPTH       2
`endif

// ===== design/i2m_pkg.sv
`default_nettype none
package i2m_pkg;
    typedef enum logic [2:0] {
        I2M_IDLE  = 3'b000,
        I2M_DEVA  = 3'b001,
        I2M_ADRH  = 3'b011,
        I2M_ADRL  = 3'b010,
        I2M_WDAT  = 3'b110,
        I2M_RDAT  = 3'b111,
        I2M_RACK  = 3'b101
    } i2m_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } i2m_wr_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } i2m_bus_t;
endpackage : i2m_pkg
`default_nettype wire

// ===== design/i2m_slave.sv
`default_nettype none
`include "i2m_map.svh"
module i2m_slave
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic select_strap_bit0,
    input  wire logic select_strap_bit1,
    input  wire logic select_strap_bit2,
    input  wire logic write_lock,
    output logic      busy
);
    import i2m_pkg::*;

    // Pins pass three stages; a change counts when stage 2 and 3 agree
    i2m_bus_t   s1_q;
    i2m_bus_t   s2_q;
    i2m_bus_t   s3_q;
    i2m_bus_t   bus_q;
    logic [2:0] strap_s1_q;
    logic [2:0] strap_s2_q;
    logic [2:0] strap_s3_q;
    logic [2:0] strap_q;
    logic       wl_s1_q;
    logic       wl_s2_q;
    logic       wl_s3_q;
    logic       wl_q;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_q       <= '{scl: 1'b1, sda: 1'b1};
            s2_q       <= '{scl: 1'b1, sda: 1'b1};
            s3_q       <= '{scl: 1'b1, sda: 1'b1};
            bus_q      <= '{scl: 1'b1, sda: 1'b1};
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
            strap_s3_q <= 3'h0;
            strap_q    <= 3'h0;
            wl_s1_q    <= 1'b0;
            wl_s2_q    <= 1'b0;
            wl_s3_q    <= 1'b0;
            wl_q       <= 1'b0;
        end
        else
        begin
            s1_q       <= '{scl: scl_in, sda: sda_in};
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            strap_s1_q <= {select_strap_bit2, select_strap_bit1, select_strap_bit0};
            strap_s2_q <= strap_s1_q;
            strap_s3_q <= strap_s2_q;
            wl_s1_q    <= write_lock;
            wl_s2_q    <= wl_s1_q;
            wl_s3_q    <= wl_s2_q;
            if (s2_q.scl == s3_q.scl)
                bus_q.scl <= s3_q.scl;
            if (s2_q.sda == s3_q.sda)
                bus_q.sda <= s3_q.sda;
            if (strap_s2_q == strap_s3_q)
                strap_q <= strap_s3_q;
            if (wl_s2_q == wl_s3_q)
                wl_q <= wl_s3_q;
        end
    end

    wire scl_n = (s2_q.scl == s3_q.scl) ? s3_q.scl : bus_q.scl;
    wire sda_n = (s2_q.sda == s3_q.sda) ? s3_q.sda : bus_q.sda;
    // Clock pin only read; target never drives it
    // Edge events on the filtered clock
    wire scl_rise = scl_n && !bus_q.scl;
    wire scl_fall = !scl_n && bus_q.scl;
    // Start and stop: data moves with clock high
    wire start_ev = bus_q.scl && scl_n && bus_q.sda && !sda_n;
    wire stop_ev  = bus_q.scl && scl_n && !bus_q.sda && sda_n;

    logic [7:0]  mem_q [0:`I2M_MEM_WORDS-1];
    i2m_state_t  st_q;
    logic [2:0]  bit_q;
    logic        ninth_q;
    logic [7:0]  sh_q;
    logic [15:0] addr_q;
    logic [7:0]  rd_q;
    logic        drv_low_q;
    logic        wr_valid_q;
    i2m_wr_t     wr_q;
    logic        wr_ready;
    logic        buf_valid;
    i2m_wr_t     buf_data;
    logic        busy_q;

    wire [7:0] byte_in = {sh_q[6:0], sda_n};
    // Type code then straps MSB first
    wire dev_hit = (sh_q[7:4] == `I2M_TYPE_CODE) && (sh_q[3:1] == strap_q);
    wire last_bit = (bit_q == `I2M_BIT_LAST);
    wire mem_word = buf_valid;

    // Two-entry buffer so stop needs no program wait
    i2m_wbuf u_wbuf
    (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (wr_valid_q),
        .in_ready  (wr_ready),
        .in_data   (wr_q),
        .out_valid (buf_valid),
        .out_ready (1'b1),
        .out_data  (buf_data)
    );

    always_ff @(posedge ref_clk)
    begin
        if (mem_word)
            mem_q[buf_data.addr] <= buf_data.data;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q       <= I2M_IDLE;
            bit_q      <= 3'h0;
            ninth_q    <= 1'b0;
            sh_q       <= 8'h00;
            addr_q     <= 16'h0000;
            rd_q       <= 8'h00;
            drv_low_q  <= 1'b0;
            wr_valid_q <= 1'b0;
            wr_q       <= '0;
            busy_q     <= 1'b0;
        end
        else
        begin
            if (wr_valid_q && wr_ready)
                wr_valid_q <= 1'b0;
            busy_q <= (st_q != I2M_IDLE);
            // Start restarts address byte from any state
            if (start_ev)
            begin
                st_q      <= I2M_DEVA;
                bit_q     <= 3'h0;
                ninth_q   <= 1'b0;
                drv_low_q <= 1'b0;
            end
            else if (stop_ev)
            begin
                st_q      <= I2M_IDLE;
                drv_low_q <= 1'b0;
            end
            else if (st_q != I2M_IDLE)
            begin
                if (scl_rise && !ninth_q)
                begin
                    sh_q <= byte_in;
                    if (last_bit)
                        ninth_q <= 1'b1;
                    bit_q <= bit_q + 3'h1;
                end
                else if (scl_rise && ninth_q && st_q == I2M_RACK)
                begin
                    // Master NACK ends read and releases
                    // Ack keeps the slot; next byte loads on the fall
                    if (sda_n)
                        st_q <= I2M_IDLE;
                    else
                        st_q <= I2M_RACK;
                end
                else if (scl_fall && ninth_q && !drv_low_q && st_q != I2M_RACK && st_q != I2M_RDAT)
                begin
                    case (st_q)
                        I2M_DEVA:
                        begin
                            if (!dev_hit)
                            begin
                                st_q    <= I2M_IDLE;
                                ninth_q <= 1'b0;
                            end
                            else
                                drv_low_q <= 1'b1;
                        end
                        I2M_ADRH, I2M_ADRL, I2M_WDAT:
                            drv_low_q <= 1'b1;
                        default:
                            drv_low_q <= 1'b0;
                    endcase
                end
                // Read bytes release in their own branch, whatever the last bit
                else if (scl_fall && ninth_q && drv_low_q && st_q != I2M_RDAT)
                begin
                    drv_low_q <= 1'b0;
                    ninth_q   <= 1'b0;
                    case (st_q)
                        I2M_DEVA:
                        begin
                            if (sh_q[0])
                            begin
                                st_q      <= I2M_RDAT;
                                rd_q      <= mem_q[addr_q];
                                drv_low_q <= !mem_q[addr_q][7];
                                addr_q    <= addr_q + 16'h0001;
                            end
                            else
                                st_q <= I2M_ADRH;
                        end
                        I2M_ADRH:
                        begin
                            addr_q[15:8] <= sh_q;
                            st_q         <= I2M_ADRL;
                        end
                        I2M_ADRL:
                        begin
                            addr_q[7:0] <= sh_q;
                            st_q        <= I2M_WDAT;
                        end
                        I2M_WDAT:
                        begin
                            // Lock blocks storage but byte is still acked
                            if (!wl_q)
                            begin
                                wr_valid_q <= 1'b1;
                                wr_q       <= '{addr: addr_q, data: sh_q};
                            end
                            addr_q <= addr_q + 16'h0001;
                        end
                        default:
                            st_q <= st_q;
                    endcase
                end
                else if (scl_fall && st_q == I2M_RDAT)
                begin
                    if (ninth_q)
                    begin
                        drv_low_q <= 1'b0;
                        st_q      <= I2M_RACK;
                    end
                    else
                        drv_low_q <= !rd_q[3'h7 - bit_q];
                end
                else if (scl_fall && st_q == I2M_RACK && !ninth_q)
                    st_q <= I2M_RACK;
                if (scl_fall && st_q == I2M_RACK && ninth_q && !sda_n)
                begin
                    ninth_q   <= 1'b0;
                    rd_q      <= mem_q[addr_q];
                    drv_low_q <= !mem_q[addr_q][7];
                    addr_q    <= addr_q + 16'h0001;
                    st_q      <= I2M_RDAT;
                end
            end
        end
    end

    // Open drain: data pin only ever driven low
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end
        else
        begin
            sda_out <= 1'b0;
            sda_oe  <= drv_low_q;
        end
    end

    assign busy = busy_q;

    a_sda_never_high: assert property (@(posedge ref_clk) disable iff (rst) sda_oe |-> !sda_out)
        else $error("data pin driven high");
    a_stop_release: assert property (@(posedge ref_clk) disable iff (rst)
        stop_ev |-> ##2 !sda_oe)
        else $error("bus not released after stop");
    a_stop_idle: assert property (@(posedge ref_clk) disable iff (rst)
        stop_ev && !start_ev |=> st_q == I2M_IDLE)
        else $error("not standby after stop");
    a_start_deva: assert property (@(posedge ref_clk) disable iff (rst)
        start_ev |=> st_q == I2M_DEVA)
        else $error("start not taken");
    a_lock_blocks: assert property (@(posedge ref_clk) disable iff (rst)
        wl_q && $stable(wl_q) |=> !$rose(wr_valid_q))
        else $error("write while locked");
    a_idle_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        st_q == I2M_IDLE && !start_ev |=> st_q == I2M_IDLE)
        else $error("left standby without start");
    a_mismatch_idle: assert property (@(posedge ref_clk) disable iff (rst)
        st_q == I2M_DEVA && ninth_q && scl_fall && !dev_hit && !start_ev && !stop_ev
        |=> st_q == I2M_IDLE ##1 !sda_oe)
        else $error("mismatch acknowledged");
    a_ack_hold: assert property (@(posedge ref_clk) disable iff (rst)
        drv_low_q && ninth_q && !scl_fall && !start_ev && !stop_ev |=> drv_low_q)
        else $error("ack dropped early");
    // Released in the read ack slot
    a_nine_release: assert property (@(posedge ref_clk) disable iff (rst)
        st_q == I2M_RACK |-> !drv_low_q)
        else $error("data line held in acknowledge slot");
endmodule : i2m_slave
`default_nettype wire

// ===== design/i2m_wbuf.sv
`default_nettype none
module i2m_wbuf
(
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic            in_valid,
    output logic                 in_ready,
    input  wire i2m_pkg::i2m_wr_t in_data,
    output logic                 out_valid,
    input  wire logic            out_ready,
    output i2m_pkg::i2m_wr_t     out_data
);
    import i2m_pkg::*;

    i2m_wr_t    mem_q [0:1];
    logic       wp_q;
    logic       rp_q;
    logic [1:0] cnt_q;
    wire        push = in_valid && in_ready;
    wire        pop  = out_valid && out_ready;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rp_q];

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
                wp_q <= ~wp_q;
            if (pop)
                rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem_q[wp_q] <= in_data;
    end
endmodule : i2m_wbuf
`default_nettype wire

// ===== verification/i2m_master_model.sv
`default_nettype none
module i2m_master_model
#(
    // Serial clock near 3.3 MHz, inside the high-speed limit
    parameter int HALF = 28
)
(
    input  wire logic ref_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_cyc
    // Master alone starts; data falls with clock high
    task automatic start_cond();
        sda_pull = 1'b0;
        wait_cyc(HALF);
        scl = 1'b1;
        wait_cyc(HALF);
        sda_pull = 1'b1;
        wait_cyc(HALF);
        scl = 1'b0;
    endtask : start_cond
    // Data moves with clock low; stop after release
    task automatic stop_cond();
        wait_cyc(4);
        sda_pull = 1'b1;
        wait_cyc(HALF);
        scl = 1'b1;
        wait_cyc(HALF);
        sda_pull = 1'b0;
        wait_cyc(HALF);
    endtask : stop_cond
    // Hold after fall so the device never sees data move with the clock
    task automatic clock_bit(input logic b, output logic s);
        wait_cyc(4);
        sda_pull = ~b;
        wait_cyc(HALF);
        scl = 1'b1;
        wait_cyc(HALF);
        s = sda;
        scl = 1'b0;
    endtask : clock_bit
    // Eight bits MSB first, released on the ninth
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(b[i], s);
        clock_bit(1'b1, ack);
    endtask : wr_byte
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 0; i < 8; i++)
        begin
            clock_bit(1'b1, s);
            d = {d[6:0], s};
        end
        clock_bit(mack, s);
    endtask : rd_byte
endmodule : i2m_master_model
`default_nettype wire

// ===== verification/i2m_slave_bench.sv
`default_nettype none
`include "i2m_map.svh"
module i2m_slave_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import i2m_pkg::*;
    localparam logic [3:0] TC = `I2M_TYPE_CODE;
    logic       ref_clk;
    logic       rst;
    logic       scl;
    logic       sda_pull;
    logic       sda;
    logic       sda_out;
    logic       sda_oe;
    logic       busy;
    logic       write_lock;
    logic       oe_q;
    logic [2:0] strap;
    logic [3:0] type_rx;
    logic       a;
    logic [7:0] d;
    int         n_fail;
    int         check_count;
    int         hi_cnt;
    int         mem[int];
    int         cur;
    // Line resolved with pull-up; either party may pull low
    assign sda = ~(sda_pull | (sda_oe & ~sda_out));
    assign type_rx = TC;
    i2m_slave u_i2m_slave (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]),
        .select_strap_bit2(strap[2]), .write_lock(write_lock), .busy(busy));
    i2m_master_model u_i2m_master_model (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic final_report();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %b", $time, msg, got);
        end
    endtask : chk_bit
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_byte
    task automatic set_addr(input int ad, input logic [2:0] sel);
        u_i2m_master_model.start_cond();
        u_i2m_master_model.wr_byte({type_rx, sel, 1'b0}, a);
        chk_bit(a, 1'b0, "select ack");
        chk_bit(busy, 1'b1, "busy in transfer");
        u_i2m_master_model.wr_byte(8'(ad >> 8), a);
        chk_bit(a, 1'b0, "addr high ack");
        u_i2m_master_model.wr_byte(8'(ad), a);
        chk_bit(a, 1'b0, "addr low ack");
        cur = ad;
    endtask : set_addr
    task automatic end_xfer();
        u_i2m_master_model.stop_cond();
        chk_bit(busy, 1'b0, "standby after stop");
    endtask : end_xfer
    task automatic write_seq(input int ad, input int n);
        set_addr(ad, strap);
        repeat (n)
        begin
            d = 8'($urandom);
            u_i2m_master_model.wr_byte(d, a);
            chk_bit(a, 1'b0, "data ack");
            if (!write_lock)
                mem[cur] = d;
            cur = (cur + 1) % `I2M_MEM_WORDS;
        end
        end_xfer();
    endtask : write_seq
    task automatic read_bytes(input int n);
        for (int i = 0; i < n; i++)
        begin
            u_i2m_master_model.rd_byte(i == n - 1, d);
            if (mem.exists(cur))
                chk_byte(d, 8'(mem[cur]), "read data");
            cur = (cur + 1) % `I2M_MEM_WORDS;
        end
        end_xfer();
    endtask : read_bytes
    task automatic read_seq(input int ad, input int n);
        set_addr(ad, strap);
        u_i2m_master_model.start_cond();
        u_i2m_master_model.wr_byte({type_rx, strap, 1'b1}, a);
        chk_bit(a, 1'b0, "read select ack");
        read_bytes(n);
    endtask : read_seq
    // Device output moves only while clock low
    always @(posedge ref_clk)
    begin
        hi_cnt <= scl ? hi_cnt + 1 : 0;
        oe_q <= sda_oe;
        if (hi_cnt > 6 && sda_oe !== oe_q)
        begin
            n_fail++;
            $display("wrong value at %0t: output moved with clock high", $time);
        end
    end
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        final_report();
    end
    initial
    begin
        int ad;
        rst = 1'b1;
        write_lock = 1'b0;
        strap = 3'h0;
        void'($urandom(57569));
        repeat (16) @(posedge ref_clk);
        chk_bit(sda_oe, 1'b0, "released in reset");
        chk_bit(busy, 1'b0, "idle in reset");
        #1 rst = 1'b0;
        u_i2m_master_model.wait_cyc(4);
        for (int i = 0; i < 3; i++)
        begin
            strap = 3'($urandom);
            ad = $urandom % `I2M_MEM_WORDS;
            write_seq(ad, 3);
            read_seq(ad, 1);
            u_i2m_master_model.start_cond();
            u_i2m_master_model.wr_byte({type_rx, strap, 1'b1}, a);
            chk_bit(a, 1'b0, "current read ack");
            read_bytes(2);
        end
        // Page wraps past the top address
        write_seq(16'hFFFF, 2);
        read_seq(16'hFFFF, 2);
        write_lock = 1'b1;
        write_seq(ad, 2);
        read_seq(ad, 2);
        write_lock = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            u_i2m_master_model.start_cond();
            u_i2m_master_model.wr_byte(i < 3 ? {type_rx, strap ^ 3'(1 << i), 1'b0} : {~type_rx, strap, 1'b0}, a);
            chk_bit(a, 1'b1, "mismatch nack");
            u_i2m_master_model.clock_bit(1'b0, a);
            chk_bit(busy, 1'b0, "standby ignores bus");
            u_i2m_master_model.stop_cond();
        end
        // Stop inside a byte abandons it
        u_i2m_master_model.start_cond();
        u_i2m_master_model.wr_byte({type_rx, strap, 1'b0}, a);
        repeat (4) u_i2m_master_model.clock_bit(1'b1, a);
        end_xfer();
        write_seq(ad, 1);
        read_seq(ad, 1);
        final_report();
    end
endmodule : i2m_slave_bench
`default_nettype wire
